// ==== common/trrm_pkg.sv ====
package trrm_pkg;

    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [5:0] OFS_REGULATOR      = 6'h10;
    localparam logic [5:0] OFS_BATTERY        = 6'h11;
    localparam logic [5:0] OFS_EXT_ADDR_TOP   = 6'h2b;
    localparam logic [5:0] OFS_MAC_RETRY      = 6'h2c;
    localparam logic [5:0] OFS_SEED_LOW       = 6'h2d;
    localparam logic [5:0] OFS_ACK_SEED_HIGH  = 6'h2e;
    localparam logic [5:0] OFS_BACKOFF_EXP    = 6'h2f;
    localparam logic [5:0] OFS_STATE_REPORT   = 6'h30;
    localparam logic [5:0] OFS_DIGITAL_TEST   = 6'h36;
    localparam logic [5:0] OFS_PAGED          = 6'h3b;
    localparam logic [5:0] OFS_GAIN_TEST      = 6'h3c;
    localparam logic [5:0] OFS_MOD_TEST       = 6'h3d;

    // power-on defaults
    localparam logic [7:0] RST_REGULATOR      = 8'h00;
    localparam logic [7:0] RST_BATTERY        = 8'h02;
    localparam logic [7:0] RST_EXT_ADDR_TOP   = 8'h00;
    localparam logic [7:0] RST_MAC_RETRY      = 8'h38;
    localparam logic [7:0] RST_SEED_LOW       = 8'hea;
    localparam logic [7:0] RST_ACK_SEED_HIGH  = 8'h42;
    localparam logic [7:0] RST_BACKOFF_EXP    = 8'h53;
    localparam logic [7:0] RST_STATE_REPORT   = 8'h00;
    localparam logic [7:0] RST_DIGITAL_TEST   = 8'h00;
    localparam logic [7:0] RST_TX_TIMING      = 8'h00;
    localparam logic [7:0] RST_GAIN_TEST      = 8'h00;
    localparam logic [7:0] RST_MOD_TEST       = 8'h00;

    // status bits merged into read-back
    localparam logic [7:0] REGULATOR_OK_BIT   = 8'h04;
    localparam logic [7:0] BATTERY_OK_BIT     = 8'h20;

    // state report values loaded by a reset
    localparam logic [7:0] STATE_AFTER_PON    = 8'h11;
    localparam logic [7:0] STATE_AFTER_OTHER  = 8'h07;

    // paging selector value
    localparam logic [7:0] PAGE_ON            = 8'h01;

    // index of each plain storage register
    localparam int unsigned NUM_PLAIN         = 9;
    localparam logic [3:0] IDX_EXT_ADDR_TOP   = 4'h0;
    localparam logic [3:0] IDX_MAC_RETRY      = 4'h1;
    localparam logic [3:0] IDX_SEED_LOW       = 4'h2;
    localparam logic [3:0] IDX_ACK_SEED_HIGH  = 4'h3;
    localparam logic [3:0] IDX_BACKOFF_EXP    = 4'h4;
    localparam logic [3:0] IDX_DIGITAL_TEST   = 4'h5;
    localparam logic [3:0] IDX_TX_TIMING      = 4'h6;
    localparam logic [3:0] IDX_GAIN_TEST      = 4'h7;
    localparam logic [3:0] IDX_MOD_TEST       = 4'h8;
    localparam logic [3:0] IDX_NONE           = 4'hf;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } trrm_req_t;

    typedef struct packed {
        logic [7:0] tx_time_page_select;
        logic [7:0] power_meas_page_select;
        logic       digital_regulator;
        logic       battery_monitor;
        logic       in_pon_state;
    } trrm_status_t;

endpackage

// ==== rtl/trrm_regbank.sv ====
`timescale 1ns/1ns
`default_nettype none

module trrm_regbank #(
    parameter int unsigned DATA_W = trrm_pkg::DATA_W
) (
    // clock, reset, enable
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    input  wire logic                 clk_en,
    input  wire logic                 pin_rst_n,
    // register access from the serial host interface
    input  wire trrm_pkg::trrm_req_t  req,
    output logic [DATA_W-1:0]         rdata,
    // device status and paging
    input  wire trrm_pkg::trrm_status_t status,
    input  wire logic [DATA_W-1:0]    power_meas_value
);

    // the register map and read merge are byte wide only
    if (DATA_W != 8)
    begin : g_width_check
        $error("trrm_regbank serves 8-bit registers only");
    end

    logic [7:0] plain_q [trrm_pkg::NUM_PLAIN];
    logic [7:0] regulator_q;
    logic [7:0] battery_q;
    logic [7:0] state_report_q;
    logic [7:0] rdata_q;
    logic       pon_pending_q;
    logic [3:0] idx;
    logic       tx_page;
    logic       meas_page;

    function automatic logic [7:0] plain_default(input logic [3:0] i);
        case (i)
            trrm_pkg::IDX_MAC_RETRY:     plain_default = trrm_pkg::RST_MAC_RETRY;
            trrm_pkg::IDX_SEED_LOW:      plain_default = trrm_pkg::RST_SEED_LOW;
            trrm_pkg::IDX_ACK_SEED_HIGH: plain_default = trrm_pkg::RST_ACK_SEED_HIGH;
            trrm_pkg::IDX_BACKOFF_EXP:   plain_default = trrm_pkg::RST_BACKOFF_EXP;
            trrm_pkg::IDX_EXT_ADDR_TOP:  plain_default = trrm_pkg::RST_EXT_ADDR_TOP;
            trrm_pkg::IDX_DIGITAL_TEST:  plain_default = trrm_pkg::RST_DIGITAL_TEST;
            trrm_pkg::IDX_TX_TIMING:     plain_default = trrm_pkg::RST_TX_TIMING;
            trrm_pkg::IDX_GAIN_TEST:     plain_default = trrm_pkg::RST_GAIN_TEST;
            default:                     plain_default = trrm_pkg::RST_MOD_TEST;
        endcase
    endfunction

    assign tx_page   = (status.tx_time_page_select == trrm_pkg::PAGE_ON);
    assign meas_page = (status.power_meas_page_select == trrm_pkg::PAGE_ON);

    always_comb
    begin
        case (req.addr)
            trrm_pkg::OFS_EXT_ADDR_TOP:  idx = trrm_pkg::IDX_EXT_ADDR_TOP;
            trrm_pkg::OFS_MAC_RETRY:     idx = trrm_pkg::IDX_MAC_RETRY;
            trrm_pkg::OFS_SEED_LOW:      idx = trrm_pkg::IDX_SEED_LOW;
            trrm_pkg::OFS_ACK_SEED_HIGH: idx = trrm_pkg::IDX_ACK_SEED_HIGH;
            trrm_pkg::OFS_BACKOFF_EXP:   idx = trrm_pkg::IDX_BACKOFF_EXP;
            trrm_pkg::OFS_DIGITAL_TEST:  idx = trrm_pkg::IDX_DIGITAL_TEST;
            trrm_pkg::OFS_PAGED:         idx = tx_page ? trrm_pkg::IDX_TX_TIMING
                                                       : trrm_pkg::IDX_NONE;
            trrm_pkg::OFS_GAIN_TEST:     idx = trrm_pkg::IDX_GAIN_TEST;
            trrm_pkg::OFS_MOD_TEST:      idx = trrm_pkg::IDX_MOD_TEST;
            default:                     idx = trrm_pkg::IDX_NONE;
        endcase
    end

    // power-on loads every default; pin reset restores plain registers only
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < trrm_pkg::NUM_PLAIN; i++)
                plain_q[i] <= plain_default(4'(i));
        end
        else if (clk_en)
        begin
            if (!pin_rst_n)
            begin
                for (int i = 0; i < trrm_pkg::NUM_PLAIN; i++)
                    plain_q[i] <= plain_default(4'(i));
            end
            else if (req.wr && idx != trrm_pkg::IDX_NONE)
                plain_q[idx] <= req.wdata;
        end
    end

    // regulator and battery values survive a pin reset
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            regulator_q <= trrm_pkg::RST_REGULATOR;
            battery_q   <= trrm_pkg::RST_BATTERY;
        end
        else if (clk_en && pin_rst_n && req.wr)
        begin
            if (req.addr == trrm_pkg::OFS_REGULATOR)
                regulator_q <= req.wdata;
            if (req.addr == trrm_pkg::OFS_BATTERY)
                battery_q <= req.wdata;
        end
    end

    // state report loaded after each reset, by the state it was taken in
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_report_q <= trrm_pkg::RST_STATE_REPORT;
            pon_pending_q  <= 1'b1;
        end
        else if (clk_en)
        begin
            pon_pending_q <= 1'b0;
            if (!pin_rst_n)
                state_report_q <= status.in_pon_state ? trrm_pkg::STATE_AFTER_PON
                                                      : trrm_pkg::STATE_AFTER_OTHER;
            else if (pon_pending_q)
                state_report_q <= trrm_pkg::STATE_AFTER_PON;
            else if (req.wr && req.addr == trrm_pkg::OFS_STATE_REPORT)
                state_report_q <= req.wdata;
        end
    end

    // read data is registered; unmapped or unpaged reads return zero
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rdata_q <= 8'h00;
        else if (clk_en && req.rd)
        begin
            case (req.addr)
                trrm_pkg::OFS_REGULATOR:
                    rdata_q <= regulator_q |
                               (status.digital_regulator ? trrm_pkg::REGULATOR_OK_BIT : 8'h00);
                trrm_pkg::OFS_BATTERY:
                    rdata_q <= battery_q |
                               (status.battery_monitor ? trrm_pkg::BATTERY_OK_BIT : 8'h00);
                trrm_pkg::OFS_STATE_REPORT:
                    rdata_q <= state_report_q;
                default:
                begin
                    // measurement page when tx timing page is off
                    if (idx != trrm_pkg::IDX_NONE)
                        rdata_q <= plain_q[idx];
                    else if (req.addr == trrm_pkg::OFS_PAGED && meas_page)
                        rdata_q <= power_meas_value;
                    else
                        rdata_q <= 8'h00;
                end
            endcase
        end
    end

    assign rdata = rdata_q;

    sequence s_pin_reset_in_other;
        clk_en && !pin_rst_n && !status.in_pon_state;
    endsequence

    sequence s_pin_released;
        clk_en && pin_rst_n;
    endsequence

    AST_POR_DEFAULT: assert property (@(posedge clock)
        $rose(arst_n) |-> plain_q[trrm_pkg::IDX_MAC_RETRY] == trrm_pkg::RST_MAC_RETRY
                       && plain_q[trrm_pkg::IDX_BACKOFF_EXP] == trrm_pkg::RST_BACKOFF_EXP)
        else $error("power-on defaults not loaded");

    AST_PIN_KEEPS_REG: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && !pin_rst_n |=> regulator_q == $past(regulator_q))
        else $error("regulator value lost on pin reset");

    AST_REG_READ: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && req.rd && req.addr == trrm_pkg::OFS_REGULATOR && status.digital_regulator
        && regulator_q == trrm_pkg::RST_REGULATOR |=> rdata == 8'h04)
        else $error("regulator read-back wrong");

    AST_BAT_READ: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && req.rd && req.addr == trrm_pkg::OFS_BATTERY && status.battery_monitor
        && battery_q == trrm_pkg::RST_BATTERY |=> rdata == 8'h22)
        else $error("battery read-back wrong");

    AST_STATE_OTHER: assert property (@(posedge clock) disable iff (!arst_n)
        s_pin_reset_in_other ##1 s_pin_released |-> state_report_q == 8'h07)
        else $error("state report after non-pon reset wrong");

    AST_STATE_PON: assert property (@(posedge clock) disable iff (!arst_n)
        $past(pon_pending_q) && !pon_pending_q && pin_rst_n && $past(pin_rst_n)
        && $past(clk_en) |-> state_report_q == 8'h11)
        else $error("state report after power-on wrong");

    AST_PAGE_TX: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && req.rd && req.addr == trrm_pkg::OFS_PAGED && tx_page
        |=> rdata == $past(plain_q[trrm_pkg::IDX_TX_TIMING]))
        else $error("tx timing page read wrong");

    AST_PAGE_MEAS: assert property (@(posedge clock) disable iff (!arst_n)
        clk_en && req.rd && req.addr == trrm_pkg::OFS_PAGED && !tx_page && meas_page
        |=> rdata == $past(power_meas_value))
        else $error("measurement page read wrong");

endmodule // trrm_regbank

`default_nettype wire

// ==== test/trrm_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module trrm_host_model (
    // clock
    input  wire logic                clock,
    // register access
    output var  trrm_pkg::trrm_req_t req,
    input  wire logic [7:0]          rdata
);
    initial req = '0;

    // released lines show the inverse of the last value, never a stale copy
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        #1;
        d = rdata;
    endtask
endmodule // trrm_host_model

`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic                   clock     = 1'b0;
    logic                   arst_n    = 1'b0;
    logic                   pin_rst_n = 1'b1;
    logic                   clk_en    = 1'b1;
    trrm_pkg::trrm_req_t    req;
    trrm_pkg::trrm_status_t status    = '{8'h01, 8'h00, 1'b1, 1'b1, 1'b1};
    logic [7:0]             pmv       = 8'h9c;
    logic [7:0]             rdata;
    logic [7:0]             got;
    int                     err_count = 0;
    int                     checked   = 0;
    int                     cyc       = 0;
    logic [5:0] ofs [9] = '{6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h36, 6'h3b, 6'h3c, 6'h3d};
    logic [7:0] dfl [9] = '{8'h00, 8'h38, 8'hea, 8'h42, 8'h53, 8'h00, 8'h00, 8'h00, 8'h00};

    trrm_regbank i_dut (
        .clock(clock), .arst_n(arst_n), .clk_en(clk_en), .pin_rst_n(pin_rst_n),
        .req(req), .rdata(rdata), .status(status), .power_meas_value(pmv)
    );
    trrm_host_model i_host (.clock(clock), .req(req), .rdata(rdata));

    always #5 clock = ~clock;

    task automatic tally_and_finish();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // read one register and compare against the expected byte
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        i_host.rd(a, got);
        checked++;
        if (got !== e)
        begin
            err_count++;
            $display("[ERR] %0t addr %h got %h exp %h", $time, a, got, e);
        end
    endtask

    // bounded run: the whole sequence needs well under a thousand cycles
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        for (int i = 0; i < 9; i++) rchk(ofs[i], dfl[i]);
        rchk(6'h10, 8'h04);
        rchk(6'h11, 8'h22);
        rchk(6'h30, 8'h11);
        rchk(6'h01, 8'h00);
        $display("test defaults done");

        for (int i = 0; i < 9; i++) i_host.wr(ofs[i], ~dfl[i]);
        for (int i = 0; i < 9; i++) rchk(ofs[i], ~dfl[i]);
        i_host.wr(6'h10, 8'h40);
        rchk(6'h10, 8'h44);
        status.digital_regulator <= 1'b0;
        rchk(6'h10, 8'h40);
        i_host.wr(6'h11, 8'h05);
        status.battery_monitor <= 1'b0;
        rchk(6'h11, 8'h05);
        $display("test write back done");

        status.tx_time_page_select <= 8'h00;
        status.power_meas_page_select <= 8'h01;
        rchk(6'h3b, 8'h9c);
        i_host.wr(6'h3b, 8'h11);
        status.power_meas_page_select <= 8'h00;
        rchk(6'h3b, 8'h00);
        status.tx_time_page_select <= 8'h01;
        status.power_meas_page_select <= 8'h01;
        rchk(6'h3b, 8'hff);
        $display("test paging done");

        // the write lands while the pin is low and must be dropped
        for (int p = 0; p < 2; p++)
        begin
            status.in_pon_state <= p[0];
            @(posedge clock) pin_rst_n <= 1'b0;
            i_host.wr(6'h2c, 8'h01);
            pin_rst_n <= 1'b1;
            rchk(6'h30, p[0] ? 8'h11 : 8'h07);
            rchk(6'h10, 8'h40);
            rchk(6'h11, 8'h05);
        end
        for (int i = 0; i < 9; i++) rchk(ofs[i], dfl[i]);
        clk_en <= 1'b0;
        i_host.wr(6'h2d, 8'h77);
        clk_en <= 1'b1;
        rchk(6'h2d, 8'hea);
        $display("test pin reset done");

        status.digital_regulator <= 1'b1;
        status.battery_monitor <= 1'b1;
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        rchk(6'h10, 8'h04);
        rchk(6'h30, 8'h11);
        rchk(6'h11, 8'h22);
        $display("test second power-on done");
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
